// ===== core/rcoc_pkg.sv
package rcoc_pkg;

   // serial frame layout: read flag, register address, register data
   localparam int unsigned FRAME_W     = 32;
   localparam int unsigned ADDR_W      = 5;
   localparam int unsigned DATA_W      = 26;
   localparam int unsigned HDR_W       = 1 + ADDR_W;
   localparam int unsigned CNT_W       = 6;
   localparam logic [CNT_W-1:0] CNT_HDR  = 6'h06;
   localparam logic [CNT_W-1:0] CNT_FULL = 6'h20;
   localparam int unsigned RW_POS      = FRAME_W - 1;

   // register addresses
   localparam logic [ADDR_W-1:0] ADDR_RX_GAIN = 5'h02;
   localparam logic [ADDR_W-1:0] ADDR_GPO_A   = 5'h07;
   localparam logic [ADDR_W-1:0] ADDR_GPO_B   = 5'h17;
   localparam logic [ADDR_W-1:0] ADDR_TX_LO_REFERENCE_REG = 5'h1d;

   // reset values
   localparam logic [DATA_W-1:0] RST_RX_GAIN  = 26'h0000000;
   localparam logic [DATA_W-1:0] RST_GPO_A    = 26'h0000000;
   localparam logic [DATA_W-1:0] RST_GPO_B    = 26'h0000000;
   localparam logic [DATA_W-1:0] RST_TX_LO_REFERENCE_REG = 26'h0000000;

   // field positions
   localparam int unsigned REF_EN_POS    = 14;
   localparam int unsigned REF_LVL_POS   = 23;
   localparam int unsigned GENERAL_OUT_TWO_LSB      = 2;
   localparam int unsigned GENERAL_OUT_THREE_LSB      = 4;
   localparam int unsigned GENERAL_OUT_ONE_LSB      = 24;
   localparam int unsigned LNA_LSB       = 14;
   localparam int unsigned BBG_LSB       = 8;
   localparam int unsigned RXSEL_LSB     = 16;
   localparam int unsigned GSM_POS       = 18;
   localparam int unsigned BBG_W         = 4;

   // modulator sample rates, in kHz
   localparam int unsigned SD_RATE_WCDMA_KHZ = 153600;
   localparam int unsigned SD_RATE_GSM_KHZ   = 26000;

   typedef enum logic [1:0] {
      RCOC_REF_OFF  = 2'h0,
      RCOC_REF_CMOS = 2'h1,
      RCOC_REF_LV   = 2'h2
   } rcoc_ref_mode_t;

   typedef enum logic [1:0] {
      RCOC_GPO_LOW   = 2'h0,
      RCOC_GPO_HIGH  = 2'h1,
      RCOC_GPO_LOCK  = 2'h2,
      RCOC_GPO_NLOCK = 2'h3
   } rcoc_gpo_mode_t;

   typedef enum logic [1:0] {
      RCOC_LNA_HIGH = 2'h0,
      RCOC_LNA_MED  = 2'h1,
      RCOC_LNA_LOW  = 2'h2
   } rcoc_lna_t;

   typedef enum logic [1:0] {
      RCOC_IN_ONE   = 2'h0,
      RCOC_IN_THREE = 2'h1,
      RCOC_IN_FOUR  = 2'h2,
      RCOC_IN_FIVE  = 2'h3
   } rcoc_rx_in_t;

   // gray along idle -> shift -> commit
   typedef enum logic [1:0] {
      RCOC_ST_IDLE   = 2'h0,
      RCOC_ST_SHIFT  = 2'h1,
      RCOC_ST_COMMIT = 2'h3
   } rcoc_state_t;

   typedef struct packed {
      logic i;
      logic q;
   } rcoc_iq_t;

endpackage

// ===== core/rcoc_buf2.sv
`timescale 1ns/100ps
// two-entry buffer, registered outputs on both sides
module rcoc_buf2 #(
   parameter int unsigned WIDTH = 2,
   parameter int unsigned DEPTH = 2
) (
   input  wire logic             i_clk,     // clock
   input  wire logic             i_rst,     // async reset, high
   input  wire logic [WIDTH-1:0] i_data,    // fill data
   input  wire logic             i_valid,   // fill valid
   output logic                  o_ready,   // room available
   output logic [WIDTH-1:0]      o_data,    // head word
   output logic                  o_valid,   // head valid
   input  wire logic             i_ready    // drain accepts
);
   logic [WIDTH-1:0] head_q, head_d, tail_q, tail_d;
   logic [1:0]       cnt_q, cnt_d;
   logic             push, pop;

   // refuse shapes this structure cannot serve, at elaboration
   if (DEPTH != 2 || WIDTH < 1) begin : g_bad_shape
      $error("rcoc_buf2 supports depth 2 and width >= 1 only");
   end

   // occupancy and slot update
   always_comb begin
      push   = i_valid & o_ready;
      pop    = o_valid & i_ready;
      head_d = head_q;
      tail_d = tail_q;
      cnt_d  = cnt_q;
      case (cnt_q)
         2'h0: begin
            if (push) begin
               head_d = i_data;
               cnt_d  = 2'h1;
            end
         end
         2'h1: begin
            if (push && pop) begin
               head_d = i_data;
            end else if (push) begin
               tail_d = i_data;
               cnt_d  = 2'h2;
            end else if (pop) begin
               cnt_d = 2'h0;
            end
         end
         2'h2: begin
            if (pop) begin
               head_d = tail_q;
               cnt_d  = 2'h1;
            end
         end
         default: cnt_d = 2'h0;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         head_q  <= '0;
         tail_q  <= '0;
         cnt_q   <= 2'h0;
         o_ready <= 1'b0;
         o_valid <= 1'b0;
      end else begin
         head_q  <= head_d;
         tail_q  <= tail_d;
         cnt_q   <= cnt_d;
         o_ready <= (cnt_d != 2'h2);
         o_valid <= (cnt_d != 2'h0);
      end
   end

   assign o_data = head_q;
endmodule

// ===== core/rcoc_top.sv
`timescale 1ns/100ps
// Function
// - a high strap forces the reference output to full-swing cmos.
// - with the strap low, only register bits pick the reference type.
// - strap low: bit 14 clear is off, else bit 23 picks cmos or lv.
// - output three follows a register 7 field or shows lock detect.
// - output two follows bits 3 down to 2 of register 7.
// - output one follows bits 25 down to 24 of register 23.
// - inputs one, three, five have three gain states, four only two.
// - lna gain comes from bits 15 down to 14 of the gain register.
// - baseband gain comes from bits 11 down to 8, 16 steps of 3 db.
// - modulators run at 153.6 mhz for wcdma and 26 mhz for gsm.
// - each i and q output carries the raw bitstream, nrz, uncoded.
// - no clock goes out with the bitstreams and none comes back.
// - the master frames transfers with select low; reads go on dout.
// - input data is sampled on each rising serial clock edge, up to 32 per frame.
module rcoc_top (
   input  wire logic              i_clk,           // system clock
   input  wire logic              i_rst,           // async reset, high
   input  wire logic              i_sclk,          // serial clock pin
   input  wire logic              i_cs_n,          // serial select pin
   input  wire logic              i_din,           // serial data in pin
   output logic                   o_dout,          // serial data out
   output logic                   o_dout_oe,       // dout driven
   input  wire logic              i_ref_buffer_strap, // strap pin
   input  wire logic              i_lock_detect,   // synth lock pin
   input  wire rcoc_pkg::rcoc_iq_t i_mod_data,     // modulator bits
   input  wire logic              i_mod_valid,     // modulator sample
   output logic                   o_mod_ready,     // buffer has room
   output rcoc_pkg::rcoc_iq_t     o_rx_data,       // bitstream out
   output logic                   o_rx_valid,      // bitstream valid
   input  wire logic              i_rx_ready,      // receiver takes
   output rcoc_pkg::rcoc_ref_mode_t o_ref_clock_out, // ref buffer type
   output logic                   o_general_out_one,   // gpo one
   output logic                   o_general_out_two,   // gpo two
   output logic                   o_general_out_three, // gpo three
   output rcoc_pkg::rcoc_lna_t    o_lna_gain_select,   // lna state
   output logic [3:0]             o_bb_amp_gain_select, // bb gain
   output rcoc_pkg::rcoc_rx_in_t  o_rx_input_sel,  // active input
   output logic                   o_sd_rate_gsm    // 26 mhz rate
);
   localparam int unsigned NSYNC = 5;

   logic [NSYNC-1:0] pin_in, s1_q, s2_q, s3_q, filt_q, filt_d;
   logic sclk_rise, sclk_fall, cs_fall, cs_rise;

   rcoc_pkg::rcoc_state_t st_q, st_d;
   logic [rcoc_pkg::CNT_W-1:0]   cnt_q, cnt_d;
   logic [rcoc_pkg::FRAME_W-1:0] sh_q, sh_d;
   logic [rcoc_pkg::DATA_W-1:0]  rd_q, rd_d;
   logic [rcoc_pkg::DATA_W-1:0]  rxg_q, rxg_d, gpa_q, gpa_d;
   logic [rcoc_pkg::DATA_W-1:0]  gpb_q, gpb_d, ref_q, ref_d;
   logic dout_d, oe_d;
   logic [rcoc_pkg::ADDR_W-1:0]  hdr_addr;

   rcoc_pkg::rcoc_ref_mode_t refm_d;
   logic g1_d, g2_d, g3_d;
   rcoc_pkg::rcoc_lna_t   lna_d;
   rcoc_pkg::rcoc_rx_in_t sel_d;

   // three-stage synchronisers for every pin input
   assign pin_in = {i_lock_detect, i_ref_buffer_strap, i_din, i_cs_n,
                    i_sclk};
   for (genvar g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge i_clk or posedge i_rst) begin
         // select idles high: all its stages reset high, no false frame
         if (i_rst) begin
            s1_q[g]   <= (g == 1);
            s2_q[g]   <= (g == 1);
            s3_q[g]   <= (g == 1);
            filt_q[g] <= (g == 1);
         end else begin
            s1_q[g]   <= pin_in[g];
            s2_q[g]   <= s1_q[g];
            s3_q[g]   <= s2_q[g];
            filt_q[g] <= filt_d[g];
         end
      end
      // a change counts once stages two and three agree
      always_comb begin
         filt_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : filt_q[g];
      end
   end

   // serial edges from the filtered levels
   assign sclk_rise = filt_d[0] & ~filt_q[0];
   assign sclk_fall = ~filt_d[0] & filt_q[0];
   assign cs_fall   = ~filt_d[1] & filt_q[1];
   assign cs_rise   = filt_d[1] & ~filt_q[1];
   assign hdr_addr  = sh_q[rcoc_pkg::ADDR_W-1:0];

   // lookup of a register for read-back
   function automatic logic [rcoc_pkg::DATA_W-1:0] reg_read(
      input logic [rcoc_pkg::ADDR_W-1:0] a,
      input logic [rcoc_pkg::DATA_W-1:0] r0, r1, r2, r3);
      case (a)
         rcoc_pkg::ADDR_RX_GAIN:  reg_read = r0;
         rcoc_pkg::ADDR_GPO_A:    reg_read = r1;
         rcoc_pkg::ADDR_GPO_B:    reg_read = r2;
         rcoc_pkg::ADDR_TX_LO_REFERENCE_REG: reg_read = r3;
         default:                 reg_read = '0;
      endcase
   endfunction

   // serial frame engine and register file
   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      sh_d   = sh_q;
      rd_d   = rd_q;
      rxg_d  = rxg_q;
      gpa_d  = gpa_q;
      gpb_d  = gpb_q;
      ref_d  = ref_q;
      dout_d = o_dout;
      oe_d   = o_dout_oe;
      case (st_q)
         rcoc_pkg::RCOC_ST_IDLE: begin
            oe_d = 1'b0;
            if (cs_fall) begin
               st_d  = rcoc_pkg::RCOC_ST_SHIFT;
               cnt_d = '0;
            end
         end
         rcoc_pkg::RCOC_ST_SHIFT: begin
            if (cs_rise) begin
               st_d = rcoc_pkg::RCOC_ST_COMMIT;
               oe_d = 1'b0;
            end else if (sclk_rise && cnt_q != rcoc_pkg::CNT_FULL) begin
               sh_d  = {sh_q[rcoc_pkg::FRAME_W-2:0], filt_q[2]};
               cnt_d = cnt_q + 6'h01;
            end else if (sclk_fall && cnt_q == rcoc_pkg::CNT_HDR &&
                         sh_q[rcoc_pkg::HDR_W-1]) begin
               // read header done: present register msb first
               {dout_d, rd_d} = {reg_read(hdr_addr, rxg_q, gpa_q, gpb_q,
                                 ref_q), 1'b0};
               oe_d = 1'b1;
            end else if (sclk_fall && o_dout_oe) begin
               {dout_d, rd_d} = {rd_q, 1'b0};
            end
         end
         rcoc_pkg::RCOC_ST_COMMIT: begin
            st_d = rcoc_pkg::RCOC_ST_IDLE;
            // only a whole write frame updates a register
            if (cnt_q == rcoc_pkg::CNT_FULL && !sh_q[rcoc_pkg::RW_POS]) begin
               case (sh_q[rcoc_pkg::FRAME_W-2 -: rcoc_pkg::ADDR_W])
                  rcoc_pkg::ADDR_RX_GAIN:
                     rxg_d = sh_q[rcoc_pkg::DATA_W-1:0];
                  rcoc_pkg::ADDR_GPO_A:
                     gpa_d = sh_q[rcoc_pkg::DATA_W-1:0];
                  rcoc_pkg::ADDR_GPO_B:
                     gpb_d = sh_q[rcoc_pkg::DATA_W-1:0];
                  rcoc_pkg::ADDR_TX_LO_REFERENCE_REG:
                     ref_d = sh_q[rcoc_pkg::DATA_W-1:0];
                  default: ;
               endcase
            end
         end
         default: st_d = rcoc_pkg::RCOC_ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_q      <= rcoc_pkg::RCOC_ST_IDLE;
         cnt_q     <= '0;
         sh_q      <= '0;
         rd_q      <= '0;
         rxg_q     <= rcoc_pkg::RST_RX_GAIN;
         gpa_q     <= rcoc_pkg::RST_GPO_A;
         gpb_q     <= rcoc_pkg::RST_GPO_B;
         ref_q     <= rcoc_pkg::RST_TX_LO_REFERENCE_REG;
         o_dout    <= 1'b0;
         o_dout_oe <= 1'b0;
      end else begin
         st_q      <= st_d;
         cnt_q     <= cnt_d;
         sh_q      <= sh_d;
         rd_q      <= rd_d;
         rxg_q     <= rxg_d;
         gpa_q     <= gpa_d;
         gpb_q     <= gpb_d;
         ref_q     <= ref_d;
         o_dout    <= dout_d;
         o_dout_oe <= oe_d;
      end
   end

   // general output drive from a two-bit mode field
   function automatic logic gpo_drive(input logic [1:0] m,
                                      input logic lock);
      case (rcoc_pkg::rcoc_gpo_mode_t'(m))
         rcoc_pkg::RCOC_GPO_HIGH:  gpo_drive = 1'b1;
         rcoc_pkg::RCOC_GPO_LOCK:  gpo_drive = lock;
         rcoc_pkg::RCOC_GPO_NLOCK: gpo_drive = ~lock;
         default:                  gpo_drive = 1'b0;
      endcase
   endfunction

   // decode of fields onto the control outputs
   always_comb begin
      if (filt_q[3]) begin
         refm_d = rcoc_pkg::RCOC_REF_CMOS;
      end else if (!ref_q[rcoc_pkg::REF_EN_POS]) begin
         refm_d = rcoc_pkg::RCOC_REF_OFF;
      end else if (ref_q[rcoc_pkg::REF_LVL_POS]) begin
         refm_d = rcoc_pkg::RCOC_REF_LV;
      end else begin
         refm_d = rcoc_pkg::RCOC_REF_CMOS;
      end
      g1_d = gpo_drive(gpb_q[rcoc_pkg::GENERAL_OUT_ONE_LSB +: 2], filt_q[4]);
      g2_d = gpo_drive(gpa_q[rcoc_pkg::GENERAL_OUT_TWO_LSB +: 2], filt_q[4]);
      g3_d = gpo_drive(gpa_q[rcoc_pkg::GENERAL_OUT_THREE_LSB +: 2], filt_q[4]);
      sel_d = rcoc_pkg::rcoc_rx_in_t'(rxg_q[rcoc_pkg::RXSEL_LSB +: 2]);
      lna_d = rcoc_pkg::rcoc_lna_t'(rxg_q[rcoc_pkg::LNA_LSB +: 2]);
      // input four lacks medium gain; unused code falls to low
      if (lna_d != rcoc_pkg::RCOC_LNA_HIGH &&
          (sel_d == rcoc_pkg::RCOC_IN_FOUR ||
           lna_d != rcoc_pkg::RCOC_LNA_MED)) begin
         lna_d = rcoc_pkg::RCOC_LNA_LOW;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_ref_clock_out      <= rcoc_pkg::RCOC_REF_OFF;
         o_general_out_one    <= 1'b0;
         o_general_out_two    <= 1'b0;
         o_general_out_three  <= 1'b0;
         o_lna_gain_select    <= rcoc_pkg::RCOC_LNA_HIGH;
         o_bb_amp_gain_select <= '0;
         o_rx_input_sel       <= rcoc_pkg::RCOC_IN_ONE;
         o_sd_rate_gsm        <= 1'b0;
      end else begin
         o_ref_clock_out      <= refm_d;
         o_general_out_one    <= g1_d;
         o_general_out_two    <= g2_d;
         o_general_out_three  <= g3_d;
         o_lna_gain_select    <= lna_d;
         o_bb_amp_gain_select <=
            rxg_q[rcoc_pkg::BBG_LSB +: rcoc_pkg::BBG_W];
         o_rx_input_sel       <= sel_d;
         o_sd_rate_gsm        <= rxg_q[rcoc_pkg::GSM_POS];
      end
   end

   // raw i/q bits pass unchanged, no clock beside them
   rcoc_buf2 #(
      .WIDTH ($bits(rcoc_pkg::rcoc_iq_t)),
      .DEPTH (2)
   ) u_buf (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_data  (i_mod_data),
      .i_valid (i_mod_valid),
      .o_ready (o_mod_ready),
      .o_data  (o_rx_data),
      .o_valid (o_rx_valid),
      .i_ready (i_rx_ready)
   );
endmodule

// ===== dv/rcoc_top_asserts.sv
`timescale 1ns/100ps
// checker on the top ports of the control block
module rcoc_top_asserts (
   input wire logic                     i_clk,               // clock
   input wire logic                     i_rst,               // reset
   input wire logic                     i_cs_n,              // select
   input wire logic                     i_ref_buffer_strap,  // strap
   input wire logic                     i_mod_valid,         // push
   input wire logic                     i_rx_ready,          // pop
   input wire logic                     o_dout_oe,           // dout on
   input wire logic                     o_mod_ready,         // room
   input wire rcoc_pkg::rcoc_iq_t       o_rx_data,           // head
   input wire logic                     o_rx_valid,          // head ok
   input wire rcoc_pkg::rcoc_ref_mode_t o_ref_clock_out,     // ref type
   input wire rcoc_pkg::rcoc_lna_t      o_lna_gain_select,   // lna
   input wire logic [3:0]               o_bb_amp_gain_select, // bb
   input wire rcoc_pkg::rcoc_rx_in_t    o_rx_input_sel       // input
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   // strap, stream buffer, serial framing and gain fields
   a_ref_strap_cmos: assert property (i_ref_buffer_strap [*8] |->
      o_ref_clock_out == rcoc_pkg::RCOC_REF_CMOS) else $error("ref not cmos");
   a_gain_hold: assert property ((!i_cs_n) [*8] |->
      $stable(o_lna_gain_select) && $stable(o_bb_amp_gain_select) &&
      $stable(o_rx_input_sel)) else $error("gain moved mid frame");
   a_rx_hold: assert property (o_rx_valid && !i_rx_ready |=>
      o_rx_valid && $stable(o_rx_data)) else $error("head word lost");
   a_rx_push: assert property (i_mod_valid && o_mod_ready |=>
      o_rx_valid) else $error("pushed word not shown");
   a_full_hold: assert property (!o_mod_ready && o_rx_valid &&
      !i_rx_ready |=> !o_mod_ready) else $error("full buffer took room");
   a_pop_room: assert property (o_rx_valid && i_rx_ready |=>
      o_mod_ready) else $error("no room after pop");
   a_dout_idle: assert property (i_cs_n [*8] |-> !o_dout_oe)
      else $error("dout driven outside frame");
   a_four_two: assert property (o_rx_input_sel ==
      rcoc_pkg::RCOC_IN_FOUR |-> o_lna_gain_select != rcoc_pkg::RCOC_LNA_MED)
      else $error("medium gain on input four");
   a_lna_legal: assert property (o_lna_gain_select != 2'h3)
      else $error("lna code out of range");
endmodule

bind rcoc_top rcoc_top_asserts i_chk (.i_clk, .i_rst, .i_cs_n,
   .i_ref_buffer_strap, .i_mod_valid, .i_rx_ready, .o_dout_oe, .o_mod_ready,
   .o_rx_data, .o_rx_valid, .o_ref_clock_out, .o_lna_gain_select,
   .o_bb_amp_gain_select, .o_rx_input_sel);

// ===== dv/rcoc_host.sv
`timescale 1ns/100ps
// serial host: frames a transfer, msb first, slow serial clock
module rcoc_host (
   input  wire logic i_clk,   // system clock
   input  wire logic i_dout,  // read data
   output logic      o_sclk,  // serial clock
   output logic      o_cs_n,  // select, low in frame
   output logic      o_din    // serial data
);
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_din  = 1'b0;
   end
   // n rises; read bits caught just before each rise
   task automatic xfer(input logic [31:0] f, input int n,
                       output logic [25:0] rd);
      int k;
      rd = 26'h0;
      @(posedge i_clk) #1 o_cs_n = 1'b0;
      for (k = 31; k > 31 - n; k--) begin
         o_din = f[k];
         repeat (6) @(posedge i_clk);
         if (k < 26) rd[k] = i_dout;
         #1 o_sclk = 1'b1;
         repeat (5) @(posedge i_clk);
         #1 o_sclk = 1'b0;
      end
      repeat (5) @(posedge i_clk);
      #1 o_cs_n = 1'b1;
      o_din = ~o_din; // released line shows no stale bit
      repeat (12) @(posedge i_clk);
   endtask
endmodule

// ===== dv/tb.sv
`timescale 1ns/100ps
// bench: register and stream models against the control block
module tb;
   localparam logic [4:0] A_G = rcoc_pkg::ADDR_RX_GAIN;
   localparam logic [4:0] A_7 = rcoc_pkg::ADDR_GPO_A;
   localparam logic [4:0] A_23 = rcoc_pkg::ADDR_GPO_B;
   localparam logic [4:0] A_R = rcoc_pkg::ADDR_TX_LO_REFERENCE_REG;
   logic i_clk, i_rst, i_sclk, i_cs_n, i_din, o_dout, o_dout_oe;
   logic i_ref_buffer_strap, i_lock_detect, i_mod_valid, o_mod_ready;
   logic o_rx_valid, i_rx_ready, o_general_out_one, o_general_out_two;
   logic o_general_out_three, o_sd_rate_gsm;
   rcoc_pkg::rcoc_iq_t       i_mod_data, o_rx_data;
   rcoc_pkg::rcoc_ref_mode_t o_ref_clock_out;
   rcoc_pkg::rcoc_lna_t      o_lna_gain_select;
   logic [3:0]               o_bb_amp_gain_select;
   rcoc_pkg::rcoc_rx_in_t    o_rx_input_sel;
   rcoc_pkg::rcoc_iq_t       sq[$];
   logic [25:0]              rm[32];
   logic [31:0]              seed, r, w, sr;
   logic [4:0]               ra;
   int                       n_errors, n_checks, smode, cyc, k;

   rcoc_top i_dut (.i_clk, .i_rst, .i_sclk, .i_cs_n, .i_din, .o_dout,
      .o_dout_oe, .i_ref_buffer_strap, .i_lock_detect, .i_mod_data,
      .i_mod_valid, .o_mod_ready, .o_rx_data, .o_rx_valid, .i_rx_ready,
      .o_ref_clock_out, .o_general_out_one, .o_general_out_two,
      .o_general_out_three, .o_lna_gain_select, .o_bb_amp_gain_select,
      .o_rx_input_sel, .o_sd_rate_gsm);
   rcoc_host i_host (.i_clk, .i_dout(o_dout), .o_sclk(i_sclk),
      .o_cs_n(i_cs_n), .o_din(i_din));

   // clock and cycle ceiling
   initial i_clk = 1'b0;
   always #4 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 60000) begin
         n_errors++;
         stop_test();
      end
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e);
      end
   endtask

   // stream source and receiver: 0 random, 1 fill, 2 drain, 3 idle
   always @(posedge i_clk) begin
      #1 sr = rnd();
      i_mod_data = rcoc_pkg::rcoc_iq_t'(sr[1:0]);
      i_mod_valid = smode == 1 || (smode == 0 && sr[2]);
      i_rx_ready = smode == 2 || (smode == 0 && sr[3]);
   end
   // receiver on its own local clock, no clock from the block
   always @(posedge i_clk) begin
      if (!i_rst && o_rx_valid && i_rx_ready)
         chk(32'(o_rx_data), 32'(sq.pop_front()));
      if (!i_rst && i_mod_valid && o_mod_ready) sq.push_back(i_mod_data);
   end

   task automatic wr(input logic [4:0] a, input logic [25:0] d, input int n);
      logic [25:0] rd;
      i_host.xfer({1'b0, a, d}, n, rd);
      if (n == 32 && a inside {A_G, A_7, A_23, A_R}) rm[a] = d;
   endtask
   task automatic rdchk(input logic [4:0] a);
      logic [25:0] rd;
      i_host.xfer({1'b1, a, 26'h0}, 32, rd);
      chk(32'(rd), 32'(rm[a]));
   endtask
   function automatic logic gpo(input logic [1:0] m);
      return m[1] ? i_lock_detect ^ m[0] : m[0];
   endfunction

   // every register driven output against the model
   task automatic cmp_all();
      logic [1:0] c, s, e;
      e = i_ref_buffer_strap ? 2'h1 : !rm[A_R][14] ? 2'h0 :
         rm[A_R][23] ? 2'h2 : 2'h1;
      chk(32'(o_ref_clock_out), 32'(e));
      chk(32'(o_general_out_three), 32'(gpo(rm[A_7][5:4])));
      chk(32'(o_general_out_two), 32'(gpo(rm[A_7][3:2])));
      chk(32'(o_general_out_one), 32'(gpo(rm[A_23][25:24])));
      c = rm[A_G][15:14];
      s = rm[A_G][17:16];
      e = (c == 2'h3 || (c == 2'h1 && s == 2'h2)) ? 2'h2 : c;
      chk(32'(o_lna_gain_select), 32'(e));
      chk(32'(o_bb_amp_gain_select), 32'(rm[A_G][11:8]));
      chk(32'(o_rx_input_sel), 32'(s));
      chk(32'(o_sd_rate_gsm), 32'(rm[A_G][18]));
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      {i_rst, seed, smode} = {1'b1, 32'h52, 32'h3};
      {i_ref_buffer_strap, i_lock_detect, i_mod_data} = 4'h0;
      {i_mod_valid, i_rx_ready} = 2'h0;
      for (k = 0; k < 32; k++) rm[k] = 26'h0;
      repeat (8) @(posedge i_clk);
      #1 i_rst = 1'b0;
      repeat (6) @(posedge i_clk);
      cmp_all();
      rdchk(A_R);
      $display("test reset done");
      for (k = 0; k < 8; k++) begin
         #1 i_ref_buffer_strap = k[2];
         wr(A_R, {2'h0, k[1], 8'h0, k[0], 14'h0}, 32);
         cmp_all();
      end
      $display("test ref done");
      for (k = 0; k < 4; k++) begin
         wr(A_7, 26'(k * 20), 32);
         wr(A_23, {k[1:0], 24'h0}, 32);
         cmp_all();
         #1 i_lock_detect = ~i_lock_detect;
         repeat (8) @(posedge i_clk);
         cmp_all();
      end
      $display("test gpo done");
      for (k = 0; k < 16; k++) begin
         wr(A_G, {7'h0, k[0], k[3:2], k[1:0], 2'h0, k[3:0], 8'h0}, 32);
         cmp_all();
         rdchk(A_G);
      end
      $display("test gain done");
      for (k = 0; k < 8; k++) begin
         r = rnd();
         w = rnd();
         ra = r[2] ? 5'h0b : r[1] ? (r[0] ? A_G : A_7) : (r[0] ? A_23 : A_R);
         #1 i_ref_buffer_strap = r[8];
         i_lock_detect = r[9];
         wr(ra, w[25:0], 32);
         cmp_all();
         rdchk(ra);
      end
      wr(A_G, 26'h3ffffff, 31);
      cmp_all();
      rdchk(A_G);
      $display("test serial done");
      smode = 0;
      repeat (300) @(posedge i_clk);
      smode = 1;
      repeat (8) @(posedge i_clk);
      #2 chk(32'(o_mod_ready), 32'h0);
      chk(32'(o_rx_valid), 32'h1);
      smode = 2;
      repeat (8) @(posedge i_clk);
      #2 chk(32'(o_rx_valid), 32'h0);
      chk(32'(sq.size()), 32'h0);
      smode = 3;
      $display("test stream done");
      stop_test();
   end
endmodule
